//--- src/pulse_channel.v
// One pulse channel: weighting, pending buffer, overflow latch and pulse timer
`timescale 1ns/10ps
`default_nettype none
`include "pulse_out_map.vh"
module pulse_channel (
	// Clock and reset
	input wire sys_clk,
	input wire sys_rst,
	// Configuration
	input wire [2:0] width_sel,
	input wire [1:0] qty_sel,
	input wire [`QTY_W-1:0] pulse_weight,
	input wire unit_change,
	input wire [15:0] unit_num,
	input wire [15:0] unit_den,
	input wire overflow_clear_cmd,
	// Increments of the three quantities
	input wire inc_valid,
	input wire [`QTY_W-1:0] inc_volume,
	input wire [`QTY_W-1:0] inc_heat,
	input wire [`QTY_W-1:0] inc_mass,
	// Results
	output reg pulse_out,
	output reg pulse_overflow_error,
	output reg [`BUF_W-1:0] pending
);
	localparam S_IDLE = 2'h0;
	localparam S_HIGH = 2'h1;
	localparam S_GAP = 2'h2;
	reg [1:0] state;
	reg [`CNT_W-1:0] timer;
	reg [`QTY_W-1:0] remainder;
	reg [`QTY_W-1:0] inc;
	reg [`QTY_W:0] acc;
	reg req;
	reg [`CNT_W-1:0] width_cyc;
	reg [47:0] conv;
	reg [47:0] scaled;
	wire emit_start;
	wire [`BUF_W:0] pend_sum;
	wire overflow_now;
	wire stop_out;

	always @* begin
		case (qty_sel)
			`SEL_HEAT: inc = inc_heat;
			`SEL_MASS: inc = inc_mass;
			default: inc = inc_volume;
		endcase
	end

	// width table, counted in cycles of the 10 MHz clock
	always @* begin
		case (width_sel)
			3'h1: width_cyc = `WIDTH_CYC_1;
			3'h2: width_cyc = `WIDTH_CYC_2;
			3'h3: width_cyc = `WIDTH_CYC_3;
			3'h4: width_cyc = `WIDTH_CYC_4;
			3'h5: width_cyc = `WIDTH_CYC_5;
			default: width_cyc = `WIDTH_CYC_0;
		endcase
	end

	// one request per full weight; increments are assumed below one weight plus remainder
	always @* begin
		acc = {1'b0, remainder} + {1'b0, inc};
		req = inc_valid && (pulse_weight != {`QTY_W{1'b0}}) && (acc >= {1'b0, pulse_weight});
		conv = remainder * unit_num;
		// Divide the full product before narrowing, so a large remainder does not wrap
		scaled = conv / {32'h00000000, unit_den};
	end

	assign emit_start = (state == S_IDLE) && (pending != {`BUF_W{1'b0}}) && !pulse_overflow_error;
	assign pend_sum = {1'b0, pending} + {{`BUF_W{1'b0}}, req} - {{`BUF_W{1'b0}}, emit_start};
	// Overflow seen this cycle, and the condition that silences the line
	assign overflow_now = !pulse_overflow_error && (pend_sum > {1'b0, `BUF_MAX});
	assign stop_out = pulse_overflow_error || overflow_now;

	// Remainder keeps fractional quantity; a unit change rescales it rather than zeroing
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			remainder <= {`QTY_W{1'b0}};
		end else if (unit_change && unit_den != 16'h0000) begin
			remainder <= scaled[`QTY_W-1:0];
		end else if (inc_valid) begin
			remainder <= req ? acc[`QTY_W-1:0] - pulse_weight : acc[`QTY_W-1:0];
		end
	end

	// Pending buffer and overflow latch; a fresh overflow wins over a clear in the same cycle
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			pending <= {`BUF_W{1'b0}};
			pulse_overflow_error <= 1'b0;
		end else if (pulse_overflow_error) begin
			// nothing buffered while in error; clear re-enables output
			if (overflow_clear_cmd) begin
				pulse_overflow_error <= 1'b0;
				pending <= {`BUF_W{1'b0}};
			end
		end else if (overflow_now) begin
			pulse_overflow_error <= 1'b1;
			pending <= {`BUF_W{1'b0}};
		end else begin
			pending <= pend_sum[`BUF_W-1:0];
		end
	end

	// Pulse timer: active for the width, then at least one width inactive
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			state <= S_IDLE;
			timer <= {`CNT_W{1'b0}};
			pulse_out <= 1'b0;
		end else begin
			case (state)
				S_IDLE: begin
					if (emit_start) begin
						state <= S_HIGH;
						timer <= width_cyc - 1'b1;
						pulse_out <= 1'b1;
					end
				end
				S_HIGH: begin
					// overflow cuts pulse; the gap still follows so a cut pulse never runs into the next
					if (stop_out || timer == {`CNT_W{1'b0}}) begin
						state <= S_GAP;
						timer <= width_cyc - 1'b1;
						pulse_out <= 1'b0;
					end else begin
						timer <= timer - 1'b1;
					end
				end
				S_GAP: begin
					if (timer == {`CNT_W{1'b0}})
						state <= S_IDLE;
					else
						timer <= timer - 1'b1;
				end
				default: begin
					state <= S_IDLE;
					pulse_out <= 1'b0;
				end
			endcase
		end
	end
endmodule // pulse_channel
`default_nettype wire

//--- src/pulse_out_map.vh
// Constants for the totalizer pulse output block
`ifndef PULSE_OUT_MAP_VH
`define PULSE_OUT_MAP_VH
`define CLK_HZ 10000000
`define CYC_PER_MS (`CLK_HZ / 1000)
`define WIDTH_MS_0 20
`define WIDTH_MS_1 40
`define WIDTH_MS_2 60
`define WIDTH_MS_3 100
`define WIDTH_MS_4 260
`define WIDTH_MS_5 500
`define WIDTH_CYC_0 23'h030d40
`define WIDTH_CYC_1 23'h061a80
`define WIDTH_CYC_2 23'h0927c0
`define WIDTH_CYC_3 23'h0f4240
`define WIDTH_CYC_4 23'h27ac40
`define WIDTH_CYC_5 23'h4c4b40
`define BUF_MAX 13'h1000
`define BUF_W 13
`define QTY_W 32
`define SEL_VOLUME 2'h0
`define SEL_HEAT 2'h1
`define SEL_MASS 2'h2
`define CNT_W 23
`endif

//--- src/totalizer_pulse_output.v
// Top of the totalizer pulse output: two channels and untouched totalizers
`timescale 1ns/10ps
`default_nettype none
`include "pulse_out_map.vh"
// Overview of operation
// - Pulse width chosen from six fixed lengths
// - Pulse source is volume, heat or mass
// - Second path has its own pulse line
// - Surplus pulses wait in pending buffer
// - Over 4096 pending disables output, flags error
// - In error, no emitting, no buffering
// - Totalizers keep counting despite overflow
// - Error latched until clear command re-enables
// - Unit change rescales remainder, not reset
module totalizer_pulse_output (
	// Clock and reset
	input wire sys_clk,
	input wire sys_rst,
	// Shared configuration
	input wire [2:0] width_sel,
	input wire [1:0] qty_sel,
	input wire [`QTY_W-1:0] pulse_weight,
	input wire unit_change,
	input wire [15:0] unit_num,
	input wire [15:0] unit_den,
	input wire overflow_clear_cmd,
	// Path one increments
	input wire p1_valid,
	input wire [`QTY_W-1:0] p1_volume,
	input wire [`QTY_W-1:0] p1_heat,
	input wire [`QTY_W-1:0] p1_mass,
	// Path two increments
	input wire p2_valid,
	input wire [`QTY_W-1:0] p2_volume,
	input wire [`QTY_W-1:0] p2_heat,
	input wire [`QTY_W-1:0] p2_mass,
	// Pulse lines and errors
	output wire pulse_out_one,
	output wire pulse_out_two,
	output wire overflow_error_one,
	output wire overflow_error_two,
	output wire [`BUF_W-1:0] pending_one,
	output wire [`BUF_W-1:0] pending_two,
	// Totalizers
	output reg [47:0] path_one_totalizer,
	output reg [47:0] path_two_totalizer
);
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			path_one_totalizer <= 48'h0;
			path_two_totalizer <= 48'h0;
		end else begin
			if (p1_valid)
				path_one_totalizer <= path_one_totalizer + {16'h0000, p1_volume};
			if (p2_valid)
				path_two_totalizer <= path_two_totalizer + {16'h0000, p2_volume};
		end
	end

	pulse_channel u_one (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .width_sel(width_sel), .qty_sel(qty_sel),
		.pulse_weight(pulse_weight), .unit_change(unit_change), .unit_num(unit_num),
		.unit_den(unit_den), .overflow_clear_cmd(overflow_clear_cmd), .inc_valid(p1_valid),
		.inc_volume(p1_volume), .inc_heat(p1_heat), .inc_mass(p1_mass),
		.pulse_out(pulse_out_one), .pulse_overflow_error(overflow_error_one), .pending(pending_one)
	);
	pulse_channel u_two (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .width_sel(width_sel), .qty_sel(qty_sel),
		.pulse_weight(pulse_weight), .unit_change(unit_change), .unit_num(unit_num),
		.unit_den(unit_den), .overflow_clear_cmd(overflow_clear_cmd), .inc_valid(p2_valid),
		.inc_volume(p2_volume), .inc_heat(p2_heat), .inc_mass(p2_mass),
		.pulse_out(pulse_out_two), .pulse_overflow_error(overflow_error_two), .pending(pending_two)
	);
endmodule // totalizer_pulse_output
`default_nettype wire

//--- verif/tpo_props.sv
// Port assertions for the totalizer pulse output
`timescale 1ns/10ps
`default_nettype none
module tpo_props (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Inputs
	input wire logic overflow_clear_cmd,
	input wire logic p1_valid,
	input wire logic [31:0] p1_volume,
	// Outputs
	input wire logic pulse_out_one,
	input wire logic overflow_error_one,
	input wire logic [12:0] pending_one,
	input wire logic [47:0] path_one_totalizer
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	property p_rise; $rose(pulse_out_one) |-> $past(pending_one) != 13'h0; endproperty
	a_rise: assert property (p_rise) else $error("pulse without pending");
	property p_hold; $rose(pulse_out_one) |-> pulse_out_one [*8]; endproperty
	a_hold: assert property (p_hold) else $error("pulse too short");
	property p_cap; pending_one <= 13'h1000; endproperty
	a_cap: assert property (p_cap) else $error("buffer above limit");
	property p_ovf; $rose(overflow_error_one) |-> pending_one == 13'h0; endproperty
	a_ovf: assert property (p_ovf) else $error("buffer kept on overflow");
	property p_cut; $rose(overflow_error_one) |-> !pulse_out_one; endproperty
	a_cut: assert property (p_cut) else $error("pulse kept on overflow");
	property p_quiet; overflow_error_one && $past(overflow_error_one) |-> pending_one == 13'h0 && !pulse_out_one; endproperty
	a_quiet: assert property (p_quiet) else $error("activity in error");
	property p_clear; overflow_error_one && overflow_clear_cmd |=> !overflow_error_one; endproperty
	a_clear: assert property (p_clear) else $error("clear ignored");
	property p_latch; $fell(overflow_error_one) |-> $past(overflow_clear_cmd); endproperty
	a_latch: assert property (p_latch) else $error("error dropped alone");
	property p_total; p1_valid |=> path_one_totalizer == $past(path_one_totalizer) + $past(p1_volume); endproperty
	a_total: assert property (p_total) else $error("totalizer wrong");
endmodule // tpo_props
bind totalizer_pulse_output tpo_props u_tpo_props (.*);
`default_nettype wire

//--- verif/pulse_counter.sv
// External counter of pulses on one line
`timescale 1ns/10ps
`default_nettype none
module pulse_counter (
	// Clock and line
	input wire logic sys_clk,
	input wire logic pulse_in,
	// Pulses seen
	output var logic [15:0] count = 16'h0
);
	logic last = 1'b0;
	// Leading edges only, width is judged by the checker
	always @(posedge sys_clk) begin
		last <= pulse_in;
		if (pulse_in && !last) count <= count + 16'h1;
	end
endmodule // pulse_counter
`default_nettype wire

//--- verif/totalizer_pulse_output_tb.sv
// Bench with a reference model for the totalizer pulse output
`timescale 1ns/10ps
`default_nettype none
module totalizer_pulse_output_tb;
	logic sys_clk = 0, sys_rst = 1, unit_change = 0, overflow_clear_cmd = 0, p1_valid = 0, p2_valid = 0;
	logic [2:0] width_sel = 0;
	logic [1:0] qty_sel = 0;
	logic [15:0] unit_num = 16'h3, unit_den = 16'h2;
	logic [31:0] pulse_weight = 32'ha, p1_volume = 0, p1_heat = 0, p1_mass = 0, p2_volume = 0, p2_heat = 0, p2_mass = 0;
	wire pulse_out_one, pulse_out_two, overflow_error_one, overflow_error_two;
	wire [12:0] pending_one, pending_two;
	wire [47:0] path_one_totalizer, path_two_totalizer;
	wire [15:0] cnt;
	int rem[2], pend[2], err[2], busy[2], tmr[2], n_rise = 0, n_errors = 0, num_checks = 0, seed = 90;
	longint tot[2];
	totalizer_pulse_output u_totalizer_pulse_output (.*);
	pulse_counter u_pulse_counter (.sys_clk, .pulse_in(pulse_out_one), .count(cnt));
	always #50 sys_clk = ~sys_clk;
	task chk(input logic [47:0] s, input logic [47:0] e);
		num_checks++;
		if (s !== e) begin
			n_errors++;
			$display("BAD %0t got %h want %h", $time, s, e);
		end
	endtask
	// Width in clock cycles: 10000 cycles per millisecond, codes 6 and 7 fall back to 20 ms
	function automatic int width_cycles(input logic [2:0] sel);
		case (sel)
			3'h1: return 40 * 10000;
			3'h2: return 60 * 10000;
			3'h3: return 100 * 10000;
			3'h4: return 260 * 10000;
			3'h5: return 500 * 10000;
			default: return 20 * 10000;
		endcase
	endfunction
	// Reference for one path; unselected quantities carry 30; busy is 0 idle, 1 high, 2 gap
	task step(input int c, input int q, input int s);
		int hit, go;
		hit = q >= 0 && pulse_weight != 0 && rem[c] + q >= pulse_weight;
		go = 0;
		if (q >= 0) tot[c] += s == 0 ? q : 30;
		// Remainder moves on in error too; only the buffer and new pulses stop
		if (unit_change && unit_den != 0) rem[c] = rem[c] * unit_num / unit_den;
		else if (q >= 0) begin
			rem[c] += q;
			if (hit) rem[c] -= pulse_weight;
		end
		if (overflow_clear_cmd && err[c]) begin
			err[c] = 0;
			pend[c] = 0;
		end else if (!err[c]) begin
			go = busy[c] == 0 && pend[c] > 0;
			pend[c] += hit - go;
			if (pend[c] > 4096) begin
				err[c] = 1;
				pend[c] = 0;
			end
		end
		// Pulse timer: high for the width, then a gap of the width; an overflow cuts the pulse
		if (go) begin
			busy[c] = 1;
			tmr[c] = width_cycles(width_sel);
			if (c == 0) n_rise++;
		end else if (busy[c] == 1) begin
			tmr[c]--;
			if (err[c] || tmr[c] == 0) begin
				busy[c] = 2;
				tmr[c] = width_cycles(width_sel);
			end
		end else if (busy[c] == 2) begin
			tmr[c]--;
			if (tmr[c] == 0) busy[c] = 0;
		end
	endtask
	// One clock; a negative amount leaves the path idle
	task cyc(input int q1, input int q2);
		int s;
		s = qty_sel == 3 ? 0 : qty_sel;
		p1_valid = q1 >= 0;
		p2_valid = q2 >= 0;
		p1_volume = s == 0 ? q1 : 32'h1e;
		p1_heat = s == 1 ? q1 : 32'h1e;
		p1_mass = s == 2 ? q1 : 32'h1e;
		p2_volume = s == 0 ? q2 : 32'h1e;
		p2_heat = s == 1 ? q2 : 32'h1e;
		p2_mass = s == 2 ? q2 : 32'h1e;
		step(0, q1, s);
		step(1, q2, s);
		@(negedge sys_clk);
		chk(pending_one, pend[0]);
		chk(overflow_error_one, err[0]);
		chk(pulse_out_one, busy[0] == 1);
		chk(path_one_totalizer, tot[0]);
		chk(pending_two, pend[1]);
		chk(pulse_out_two, busy[1] == 1);
		chk(overflow_error_two, err[1]);
		chk(path_two_totalizer, tot[1]);
	endtask
	task give_verdict;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		width_sel = 3'($random(seed));
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		sys_rst = 0;
		cyc(-1, -1);
		// each source with a running remainder
		for (int k = 0; k < 4; k++) begin
			qty_sel = 2'(k);
			repeat (3) cyc(4, 3);
		end
		repeat (40) cyc($random(seed) & 7, $random(seed) & 7);
		// Second reset in mid run; the model starts over with the design
		sys_rst = 1;
		p1_valid = 0;
		p2_valid = 0;
		repeat (2) @(negedge sys_clk);
		for (int i = 0; i < 2; i++) begin
			rem[i] = 0;
			pend[i] = 0;
			err[i] = 0;
			busy[i] = 0;
			tmr[i] = 0;
			tot[i] = 0;
		end
		sys_rst = 0;
		cyc(-1, -1);
		// remainder 4 becomes 6 on the unit change, so the next 4 reaches the weight of 10
		cyc(4, 4);
		unit_change = 1;
		cyc(-1, -1);
		unit_change = 0;
		cyc(4, 4);
		chk(pending_one, 13'h1);
		repeat (2) cyc(0, 0);
		repeat (4100) cyc(10, -1);
		overflow_clear_cmd = 1;
		cyc(-1, -1);
		overflow_clear_cmd = 0;
		cyc(10, -1);
		// a zero weight asks for no pulses
		pulse_weight = 32'h0;
		repeat (2) cyc(10, -1);
		chk(cnt, n_rise);
		give_verdict;
	end
	// Hang guard, about twice the expected run
	initial begin
		#900000;
		n_errors++;
		give_verdict;
	end
endmodule // totalizer_pulse_output_tb
`default_nettype wire
